/* File: hdl/core_state_pkg.sv */
// Constants and types for the program-visible core state block.
// Assumes a 32-bit Avalon-MM master with byte addresses, one word per register.
package core_state_pkg;

	// Register map, byte addresses
	localparam logic [7:0] OFS_DATA_BASE = 8'h00;
	localparam logic [7:0] OFS_ADDR_BASE = 8'h20;
	localparam logic [7:0] OFS_PC        = 8'h40;
	localparam logic [7:0] OFS_STATUS    = 8'h44;
	localparam logic [7:0] OFS_VBR       = 8'h48;
	localparam logic [7:0] OFS_ACC       = 8'h4c;
	localparam logic [7:0] OFS_MASK      = 8'h50;
	localparam logic [7:0] OFS_MAC_STATUS     = 8'h54;
	localparam logic [7:0] OFS_CMD       = 8'h58;
	localparam logic [7:0] OFS_CORE      = 8'h5c;

	// Status register fields
	localparam int SR_T  = 15;
	localparam int SR_S  = 13;
	localparam int SR_M  = 12;
	localparam int SR_I  = 8;
	localparam int SR_X  = 4;
	localparam int SR_N  = 3;
	localparam int SR_Z  = 2;
	localparam int SR_V  = 1;
	localparam int SR_C  = 0;
	localparam logic [15:0] SR_IMPL_MASK = 16'hb71f;
	localparam logic [15:0] SR_CCR_MASK  = 16'h001f;
	localparam logic [15:0] SR_RESET     = 16'h2700;
	localparam logic [31:0] VBR_MASK     = 32'hfff00000;
	localparam logic [31:0] VBR_RESET    = 32'h00000000;

	// Exception vectors and frame
	localparam logic [7:0] VEC_TRACE     = 8'h09;
	localparam logic [7:0] VEC_AUTO_BASE = 8'h18;
	localparam logic [7:0] VEC_TRAP_BASE = 8'h20;
	localparam logic [3:0] FRAME_FMT     = 4'h4;
	localparam logic [31:0] FRAME_BYTES  = 32'h00000008;
	localparam logic [31:0] INSN_BYTES   = 32'h00000004;
	localparam logic [2:0] IRQ_NMI_LEVEL = 3'h7;

	// Instruction buffer
	localparam int FIFO_DEPTH = 4;
	localparam logic [2:0] FIFO_FULL = 3'h4;

	// Command word layout
	localparam int CMD_OP   = 28;
	localparam int CMD_DST  = 25;
	localparam int CMD_DSTA = 24;
	localparam int CMD_SRC  = 21;
	localparam int CMD_SRCA = 20;
	localparam int CMD_SIZE = 18;

	typedef enum logic [3:0] {
		OP_MOVE  = 4'h0, OP_ADD   = 4'h1, OP_SUB   = 4'h2, OP_ADDX  = 4'h3,
		OP_AND   = 4'h4, OP_OR    = 4'h5, OP_BSET  = 4'h6, OP_INDEX = 4'h7,
		OP_MAC   = 4'h8, OP_DIVW  = 4'h9, OP_DIVL  = 4'ha, OP_REML  = 4'hb,
		OP_TRAP  = 4'hc, OP_RTE   = 4'hd, OP_MOVSR = 4'he, OP_NOP   = 4'hf
	} op_t;

	typedef enum logic [1:0] {
		SZ_BYTE = 2'h0, SZ_WORD = 2'h1, SZ_LONG = 2'h2, SZ_RSVD = 2'h3
	} size_t;

	typedef struct packed {
		op_t         op;
		logic [2:0]  dst;
		logic        dst_a;
		logic [2:0]  src;
		logic        src_a;
		size_t       size;
		logic [15:0] imm;
	} decoded_t;

endpackage : core_state_pkg

/* File: hdl/core_state.sv */
// Program-visible state of the processor core with its pipelines.
// Assumes a synchronous Avalon-MM master; irq_level is synchronous to clk_sys.
//
// Operation
// - Fetch side fills an instruction buffer; execute side drains it.
// - Execute has a decode stage then an execute stage that reads the operands.
// - Privilege bit selects user or supervisor register view.
// - Sixteen 32-bit registers: eight data, eight address, last is stack.
// - Data registers do bit, byte, word, long operations and indexing.
// - Reset loads the one stack pointer from the reset vector.
// - Exceptions push PC and status; return restores both.
// - Flags sit in status bits 4..0; extend feeds multiprecision add.
// - Negative flag copies result top bit.
// - Zero flag set when result is zero.
// - Overflow flag set when result does not fit the size.
// - Carry flag set on carry out of add or borrow of subtract.
// - Arithmetic copies carry to extend; others leave extend alone.
// - MAC unit has 32-bit accumulator, 16-bit mask, 8-bit status.
// - Divider does 32/16 quotient+remainder, 32/32 quotient, remainder.
// - Supervisor reaches all of status; user only the low byte.
// - Status bit layout: T15, S13, M12, mask 10..8, flags 4..0, zeros elsewhere.
// - Trace enable causes a trace exception after every instruction except a trap.
// - Privilege bit one means supervisor, zero means user.
// - Interrupt clears M; only return or status move may set it.
// - Interrupts at or below mask ignored; level 7 edge always taken.
// - Vector base low 20 bits read zero; vector is base plus offset.
// - Interrupt entry sets supervisor, clears trace, mask gets level.
//
// Decided for this implementation: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module core_state
	import core_state_pkg::*;
(
	input  wire logic        clk_sys,
	input  wire logic        reset,
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	input  wire logic [31:0] boot_stack_pointer,
	input  wire logic [31:0] boot_program_counter,
	input  wire logic [2:0]  irq_level,
	output logic             supervisor_mode,
	output logic      [31:0] vector_address,
	output logic             exception_taken
);

	logic [31:0] data_regs          [8];
	logic [31:0] address_regs       [7];
	logic [31:0] stack_pointer_reg;
	logic [31:0] program_counter;
	logic [15:0] processor_status;
	logic [31:0] vector_table_base;
	logic [31:0] mac_accumulator;
	logic [15:0] mac_mask;
	logic [7:0]  mac_status;
	logic [31:0] fifo_mem           [FIFO_DEPTH];
	logic [1:0]  fifo_rd;
	logic [1:0]  fifo_wr;
	logic [2:0]  fifo_count;
	logic        dec_valid;
	decoded_t    dec_insn;
	logic        ex_valid;
	decoded_t    ex_insn;
	logic [2:0]  irq_prev;
	logic        irq7_pend;
	logic [31:0] stack_mem          [16];

	logic [31:0] next_data_regs     [8];
	logic [31:0] next_address_regs  [7];
	logic [31:0] next_stack_pointer_reg;
	logic [31:0] next_program_counter;
	logic [15:0] next_processor_status;
	logic [31:0] next_vector_table_base;
	logic [31:0] next_mac_accumulator;
	logic [15:0] next_mac_mask;
	logic [7:0]  next_mac_status;
	logic [1:0]  next_fifo_rd;
	logic [1:0]  next_fifo_wr;
	logic [2:0]  next_fifo_count;
	logic        next_dec_valid;
	decoded_t    next_dec_insn;
	logic        next_ex_valid;
	decoded_t    next_ex_insn;
	logic        next_irq7_pend;
	logic [31:0] next_readdata;
	logic        next_waitrequest;
	logic [31:0] next_vector_address;
	logic        next_exception_taken;

	logic        bus_write;
	logic        fifo_push;
	logic        fifo_pop;
	logic        in_super;
	logic [31:0] dst_val;
	logic [31:0] src_val;
	logic [31:0] szmask;
	int          msb;
	logic [32:0] wide;
	logic [31:0] res;
	logic        wr_dst;
	logic [31:0] prod;
	logic [31:0] quot;
	logic        exc;
	logic [7:0]  exc_vec;
	logic        exc_irq;
	logic        irq_now;
	logic [15:0] sr_old;
	logic [31:0] frame_sp;
	logic [3:0]  frame_idx;
	logic [3:0]  pop_idx;
	logic        push_en;
	logic [31:0] push_fv_sr;
	logic [31:0] push_pc;

	always_comb begin
		next_data_regs         = data_regs;
		next_address_regs      = address_regs;
		next_stack_pointer_reg = stack_pointer_reg;
		next_program_counter   = program_counter;
		next_processor_status  = processor_status;
		next_vector_table_base = vector_table_base;
		next_mac_accumulator   = mac_accumulator;
		next_mac_mask          = mac_mask;
		next_mac_status        = mac_status;
		next_readdata          = readdata;
		next_waitrequest       = 1'b1;
		next_vector_address    = vector_address;
		next_exception_taken   = 1'b0;
		in_super  = processor_status[SR_S];
		dst_val   = 32'h0;
		src_val   = 32'h0;
		szmask    = 32'hffffffff;
		msb       = 31;
		wide      = 33'h0;
		res       = 32'h0;
		wr_dst    = 1'b0;
		prod      = 32'h0;
		quot      = 32'h0;
		exc       = 1'b0;
		exc_vec   = 8'h00;
		exc_irq   = 1'b0;
		irq_now   = 1'b0;
		sr_old    = 16'h0;
		frame_sp  = 32'h0;
		frame_idx = 4'h0;
		pop_idx   = stack_pointer_reg[5:2];
		push_en   = 1'b0;
		push_fv_sr = 32'h0;
		push_pc   = 32'h0;

		// Bus slave: one wait state; command writes stall while buffer full
		if ((read || write) && waitrequest &&
		    !(write && address == OFS_CMD && fifo_count == FIFO_FULL)) begin
			next_waitrequest = 1'b0;
			if (read) begin
				next_readdata = 32'h0;
				if (address[7:5] == 3'h0)
					next_readdata = data_regs[address[4:2]];
				else if (address[7:5] == 3'h1)
					next_readdata = (address[4:2] == 3'h7) ?
						stack_pointer_reg : address_regs[address[4:2]];
				else begin
					case (address)
					OFS_PC:     next_readdata = program_counter;
					OFS_STATUS: next_readdata = in_super ?
						{16'h0, processor_status} :
						{24'h0, processor_status[7:0]};
					OFS_VBR:    next_readdata = in_super ?
						vector_table_base : 32'h0;
					OFS_ACC:    next_readdata = mac_accumulator;
					OFS_MASK:   next_readdata = {16'h0, mac_mask};
					OFS_MAC_STATUS:  next_readdata = {24'h0, mac_status};
					OFS_CORE:   next_readdata = {24'h0, irq7_pend,
						ex_valid, dec_valid, 2'h0, fifo_count};
					default:    next_readdata = 32'h0;
					endcase
				end
			end
		end

		bus_write = write && !waitrequest;
		fifo_push = bus_write && address == OFS_CMD;
		if (bus_write) begin
			if (address[7:5] == 3'h0)
				next_data_regs[address[4:2]] = writedata;
			else if (address[7:5] == 3'h1) begin
				if (address[4:2] == 3'h7)
					next_stack_pointer_reg = writedata;
				else
					next_address_regs[address[4:2]] = writedata;
			end else begin
				case (address)
				OFS_PC:     next_program_counter = writedata;
				OFS_STATUS: next_processor_status = in_super ?
					writedata[15:0] & SR_IMPL_MASK :
					(processor_status & ~SR_CCR_MASK) |
					(writedata[15:0] & SR_CCR_MASK);
				OFS_VBR:    if (in_super)
					next_vector_table_base = writedata & VBR_MASK;
				OFS_ACC:    next_mac_accumulator = writedata;
				OFS_MASK:   next_mac_mask = writedata[15:0];
				OFS_MAC_STATUS:  next_mac_status = writedata[7:0];
				default:    ;
				endcase
			end
		end

		// Decode stage: pick operation, register selects and size
		fifo_pop        = fifo_count != 3'h0;
		next_dec_valid  = fifo_pop;
		next_dec_insn   = dec_insn;
		if (fifo_pop)
			next_dec_insn = '{op: op_t'(fifo_mem[fifo_rd][CMD_OP +: 4]),
				dst: fifo_mem[fifo_rd][CMD_DST +: 3],
				dst_a: fifo_mem[fifo_rd][CMD_DSTA],
				src: fifo_mem[fifo_rd][CMD_SRC +: 3],
				src_a: fifo_mem[fifo_rd][CMD_SRCA],
				size: size_t'(fifo_mem[fifo_rd][CMD_SIZE +: 2]),
				imm: fifo_mem[fifo_rd][15:0]};
		next_fifo_rd    = fifo_rd + 2'(fifo_pop);
		next_fifo_wr    = fifo_wr + 2'(fifo_push);
		next_fifo_count = fifo_count + 3'(fifo_push) - 3'(fifo_pop);
		next_ex_valid   = dec_valid;
		next_ex_insn    = dec_insn;

		// Execute stage, operands read from the live register file
		if (ex_valid) begin
			if (ex_insn.dst_a)
				dst_val = (ex_insn.dst == 3'h7) ? stack_pointer_reg :
					address_regs[ex_insn.dst];
			else
				dst_val = data_regs[ex_insn.dst];
			if (ex_insn.src_a)
				src_val = (ex_insn.src == 3'h7) ? stack_pointer_reg :
					address_regs[ex_insn.src];
			else
				src_val = data_regs[ex_insn.src];
			case (ex_insn.size)
			SZ_BYTE: begin szmask = 32'h000000ff; msb = 7; end
			SZ_WORD: begin szmask = 32'h0000ffff; msb = 15; end
			default: begin szmask = 32'hffffffff; msb = 31; end
			endcase
			next_program_counter = next_program_counter + INSN_BYTES;
			case (ex_insn.op)
			OP_MOVE, OP_AND, OP_OR: begin
				res = (ex_insn.op == OP_MOVE) ? src_val :
					(ex_insn.op == OP_AND) ? (dst_val & src_val) :
					(dst_val | src_val);
				wr_dst = 1'b1;
				next_processor_status[SR_V] = 1'b0;
				next_processor_status[SR_C] = 1'b0;
				next_processor_status[SR_N] = res[msb];
				next_processor_status[SR_Z] = (res & szmask) == 32'h0;
			end
			OP_ADD, OP_ADDX, OP_SUB: begin
				if (ex_insn.op == OP_SUB)
					wide = {1'b0, dst_val & szmask} -
						{1'b0, src_val & szmask};
				else
					wide = {1'b0, dst_val & szmask} +
						{1'b0, src_val & szmask} +
						{32'h0, ex_insn.op == OP_ADDX &&
						processor_status[SR_X]};
				res = wide[31:0];
				wr_dst = 1'b1;
				next_processor_status[SR_N] = res[msb];
				next_processor_status[SR_Z] =
					(res & szmask) == 32'h0;
				next_processor_status[SR_C] = wide[msb + 1];
				if (ex_insn.op == OP_SUB)
					next_processor_status[SR_V] =
						(dst_val[msb] != src_val[msb]) &&
						(res[msb] != dst_val[msb]);
				else
					next_processor_status[SR_V] =
						(dst_val[msb] == src_val[msb]) &&
						(res[msb] != dst_val[msb]);
				next_processor_status[SR_X] = wide[msb + 1];
			end
			OP_BSET: begin
				next_processor_status[SR_Z] = !dst_val[ex_insn.imm[4:0]];
				res = dst_val | (32'h1 << ex_insn.imm[4:0]);
				szmask = 32'hffffffff;
				wr_dst = 1'b1;
			end
			OP_INDEX: begin
				res = dst_val + ((ex_insn.size == SZ_WORD) ?
					{{16{src_val[15]}}, src_val[15:0]} : src_val);
				szmask = 32'hffffffff;
				wr_dst = 1'b1;
			end
			OP_MAC: begin
				prod = {16'h0, src_val[15:0] & mac_mask} *
					{16'h0, dst_val[15:0]};
				wide = {1'b0, mac_accumulator} + {1'b0, prod};
				next_mac_accumulator = wide[31:0];
				next_mac_status[3] = wide[31];
				next_mac_status[2] = wide[31:0] == 32'h0;
				next_mac_status[1] = wide[32];
			end
			OP_DIVW, OP_DIVL, OP_REML: begin
				szmask = 32'hffffffff;
				if ((ex_insn.op == OP_DIVW ? {16'h0, src_val[15:0]} :
				     src_val) == 32'h0)
					next_processor_status[SR_V] = 1'b1;
				else begin
					if (ex_insn.op == OP_DIVW) begin
						quot = dst_val / {16'h0, src_val[15:0]};
						res = {16'(dst_val % {16'h0, src_val[15:0]}),
							quot[15:0]};
						wr_dst = quot[31:16] == 16'h0;
					end else begin
						quot = dst_val / src_val;
						res = (ex_insn.op == OP_DIVL) ? quot :
							dst_val % src_val;
						wr_dst = 1'b1;
					end
					next_processor_status[SR_V] = !wr_dst;
					next_processor_status[SR_C] = 1'b0;
					next_processor_status[SR_N] = (ex_insn.op == OP_DIVW) ?
						res[15] : res[31];
					next_processor_status[SR_Z] = (ex_insn.op == OP_DIVW) ?
						res[15:0] == 16'h0 : res == 32'h0;
				end
			end
			OP_TRAP: begin
				exc = 1'b1;
				exc_vec = VEC_TRAP_BASE + {4'h0, ex_insn.imm[3:0]};
			end
			OP_RTE: if (in_super) begin
				next_processor_status = stack_mem[pop_idx][15:0] &
					SR_IMPL_MASK;
				next_program_counter = stack_mem[pop_idx + 4'h1];
				next_stack_pointer_reg = stack_pointer_reg + FRAME_BYTES;
			end
			OP_MOVSR: next_processor_status = in_super ?
				src_val[15:0] & SR_IMPL_MASK :
				(processor_status & ~SR_CCR_MASK) |
				(src_val[15:0] & SR_CCR_MASK);
			default: ;
			endcase
			if (wr_dst) begin
				if (ex_insn.dst_a) begin
					if (ex_insn.dst == 3'h7)
						next_stack_pointer_reg = res;
					else
						next_address_regs[ex_insn.dst] = res;
				end else
					next_data_regs[ex_insn.dst] =
						(dst_val & ~szmask) | (res & szmask);
			end
			// Trace wins over a pending interrupt; traps take their own frame
			if (!exc && processor_status[SR_T]) begin
				exc = 1'b1;
				exc_vec = VEC_TRACE;
			end
		end

		// Interrupt acceptance
		irq_now = (irq_level == IRQ_NMI_LEVEL) ? irq7_pend :
			irq_level > processor_status[SR_I +: 3];
		next_irq7_pend = (irq_level == IRQ_NMI_LEVEL &&
			irq_prev != IRQ_NMI_LEVEL) || irq7_pend;
		if (!exc && irq_now && irq_level != 3'h0 &&
		    !(ex_valid && ex_insn.op == OP_RTE)) begin
			exc = 1'b1;
			exc_irq = 1'b1;
			exc_vec = VEC_AUTO_BASE + {5'h0, irq_level};
			// Edge seen now and a take in the same cycle keeps the newer edge
			if (!(irq_level == IRQ_NMI_LEVEL && irq_prev != IRQ_NMI_LEVEL))
				next_irq7_pend = 1'b0;
		end

		// Exception entry: frame of format/vector+status, then PC
		if (exc) begin
			sr_old = next_processor_status;
			frame_sp = {next_stack_pointer_reg[31:2], 2'b00} - FRAME_BYTES;
			frame_idx = frame_sp[5:2];
			push_en = 1'b1;
			push_fv_sr = {FRAME_FMT + {2'h0, next_stack_pointer_reg[1:0]},
				4'h0, exc_vec, sr_old};
			push_pc = next_program_counter;
			next_stack_pointer_reg = frame_sp;
			next_processor_status[SR_S] = 1'b1;
			next_processor_status[SR_T] = 1'b0;
			if (exc_irq) begin
				next_processor_status[SR_M] = 1'b0;
				next_processor_status[SR_I +: 3] = irq_level;
			end
			next_vector_address = vector_table_base +
				{22'h0, exc_vec, 2'b00};
			next_program_counter = next_vector_address;
			next_exception_taken = 1'b1;
		end
		next_processor_status = next_processor_status & SR_IMPL_MASK;
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			for (int i = 0; i < 8; i++)
				data_regs[i] <= 32'h0;
			for (int i = 0; i < 7; i++)
				address_regs[i] <= 32'h0;
			// Reset vector longword 0 arrives on a port; no memory here
			stack_pointer_reg <= boot_stack_pointer;
			program_counter   <= boot_program_counter;
			processor_status  <= SR_RESET;
			vector_table_base <= VBR_RESET;
			mac_accumulator   <= 32'h0;
			mac_mask          <= 16'hffff;
			mac_status        <= 8'h00;
			fifo_rd           <= 2'h0;
			fifo_wr           <= 2'h0;
			fifo_count        <= 3'h0;
			dec_valid         <= 1'b0;
			dec_insn          <= '0;
			ex_valid          <= 1'b0;
			ex_insn           <= '0;
			irq_prev          <= 3'h0;
			irq7_pend         <= 1'b0;
			readdata          <= 32'h0;
			waitrequest       <= 1'b1;
			supervisor_mode   <= 1'b1;
			vector_address    <= 32'h0;
			exception_taken   <= 1'b0;
		end else begin
			data_regs         <= next_data_regs;
			address_regs      <= next_address_regs;
			stack_pointer_reg <= next_stack_pointer_reg;
			program_counter   <= next_program_counter;
			processor_status  <= next_processor_status;
			vector_table_base <= next_vector_table_base;
			mac_accumulator   <= next_mac_accumulator;
			mac_mask          <= next_mac_mask;
			mac_status        <= next_mac_status;
			fifo_rd           <= next_fifo_rd;
			fifo_wr           <= next_fifo_wr;
			fifo_count        <= next_fifo_count;
			dec_valid         <= next_dec_valid;
			dec_insn          <= next_dec_insn;
			ex_valid          <= next_ex_valid;
			ex_insn           <= next_ex_insn;
			irq_prev          <= irq_level;
			irq7_pend         <= next_irq7_pend;
			readdata          <= next_readdata;
			waitrequest       <= next_waitrequest;
			supervisor_mode   <= next_processor_status[SR_S];
			vector_address    <= next_vector_address;
			exception_taken   <= next_exception_taken;
		end
	end

	// Data storage, not reset: buffer slots and the 64-byte stack window
	always_ff @(posedge clk_sys) begin
		if (fifo_push)
			fifo_mem[fifo_wr] <= writedata;
		if (push_en && !reset) begin
			stack_mem[frame_idx]        <= push_fv_sr;
			stack_mem[frame_idx + 4'h1] <= push_pc;
		end
	end

endmodule : core_state

/* File: tb/core_state_sva.sv */
// Port checker for the core state block.
// Bound from the bench top; one clock, synchronous reset.
`timescale 1ns/1ps
module core_state_sva
	import core_state_pkg::*;
(
	input wire logic        clk_sys,
	input wire logic        reset,
	input wire logic [7:0]  address,
	input wire logic        read,
	input wire logic        write,
	input wire logic [31:0] readdata,
	input wire logic        waitrequest,
	input wire logic [2:0]  irq_level,
	input wire logic        supervisor_mode,
	input wire logic [31:0] vector_address,
	input wire logic        exception_taken
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (reset);
	wire logic rd_end = read && !waitrequest;

	// Command writes may stall on a full buffer, so they are left out
	a_ack_next: assert property ((read || write) && waitrequest
		&& address != OFS_CMD |=> !waitrequest)
		else $error("request not answered next cycle");
	a_ack_pulse: assert property (!waitrequest |=> waitrequest)
		else $error("waitrequest low too long");
	a_no_req: assert property (!read && !write && waitrequest
		|=> waitrequest) else $error("answer without request");
	a_reset_vals: assert property (
		$past(reset) |-> waitrequest
		&& supervisor_mode && !exception_taken)
		else $error("bad state after reset");
	a_sr_rsvd: assert property (
		rd_end && address == OFS_STATUS
		|-> readdata[31:16] == 16'h0
		&& (readdata[15:0] & ~SR_IMPL_MASK) == 16'h0)
		else $error("reserved status bits set");
	a_sr_user: assert property (
		rd_end && address == OFS_STATUS
		&& !supervisor_mode |-> readdata[31:5] == 27'h0)
		else $error("user status view too wide");
	a_vbr_align: assert property (
		rd_end && address == OFS_VBR
		|-> readdata[19:0] == 20'h0)
		else $error("vector base low bits set");
	a_vbr_user: assert property (
		rd_end && address == OFS_VBR
		&& !supervisor_mode |-> readdata == 32'h0)
		else $error("vector base seen in user state");
	a_exc_super: assert property (
		exception_taken |-> supervisor_mode)
		else $error("exception left user state");
	a_vec_table: assert property (
		exception_taken |=> vector_address[19:10] == 10'h0
		&& vector_address[1:0] == 2'h0)
		else $error("vector outside table");
	a_nmi_taken: assert property (
		$rose(irq_level == IRQ_NMI_LEVEL)
		|-> ##[1:16] exception_taken)
		else $error("level 7 request not taken");

	c_read: cover property (rd_end);
	c_exc: cover property (exception_taken);
	c_user: cover property (!supervisor_mode && rd_end);
endmodule : core_state_sva

/* File: tb/core_state_tb_top.sv */
// Self-checking bench for the core state block.
// Drives the Avalon-MM slave, boot vectors and interrupt level directly.
`timescale 1ns/1ps
module core_state_tb_top
	import core_state_pkg::*;
;
	logic        clk_sys = 1'h0;
	logic        reset = 1'h1;
	logic [7:0]  address = 8'h0;
	logic        read = 1'h0;
	logic        write = 1'h0;
	logic [31:0] writedata = 32'h0;
	logic [31:0] bsp = 32'h0;
	logic [31:0] bpc = 32'h0;
	logic [2:0]  irq_level = 3'h0;
	logic [31:0] readdata, vector_address, q, vb, sp, a, b, r;
	logic        waitrequest, supervisor_mode, exception_taken, e, s;
	logic [4:0]  f;
	logic [31:0] regs [15];
	integer      fails = 0, total_checks = 0, cyc = 0, i;
	integer      seed = 32'h4518;

	always #10 clk_sys = ~clk_sys;

	core_state i_core_state (
		.clk_sys(clk_sys), .reset(reset), .address(address),
		.read(read), .write(write), .writedata(writedata),
		.readdata(readdata), .waitrequest(waitrequest),
		.boot_stack_pointer(bsp), .boot_program_counter(bpc),
		.irq_level(irq_level), .supervisor_mode(supervisor_mode),
		.vector_address(vector_address),
		.exception_taken(exception_taken)
	);

	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report

	task automatic chk(input string n, input logic [31:0] g, x);
		total_checks++;
		if (g !== x) begin
			fails++;
			$display("[FAIL] %s exp %h got %h", n, x, g);
		end
	endtask : chk

	task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] d);
		@(posedge clk_sys);
		read <= !w;
		write <= w;
		address <= ad;
		writedata <= d;
		do @(posedge clk_sys); while (waitrequest !== 1'b0);
		q = readdata;
		read <= 1'b0;
		write <= 1'b0;
	endtask : bus

	task automatic rc(input logic [7:0] ad, input logic [31:0] x, input string n);
		bus(1'b0, ad, 32'h0);
		chk(n, q, x);
	endtask : rc

	// Execute result lands three edges after the command is accepted
	task automatic ex(input logic [31:0] c);
		bus(1'b1, OFS_CMD, c);
		repeat (4) @(posedge clk_sys);
	endtask : ex

	task automatic wex(input logic [31:0] v);
		int k;
		k = 0;
		do begin
			@(posedge clk_sys);
			k++;
		end while (exception_taken !== 1'b1 && k < 30);
		@(posedge clk_sys);
		chk("exception", 32'(k < 30), 32'h1);
		chk("vector", vector_address, v);
	endtask : wex

	function automatic logic [31:0] cmd(op_t o, logic [2:0] d, logic [2:0] sr,
			logic [15:0] m);
		return {o, d, 1'b0, sr, 1'b0, SZ_LONG, 2'h0, m};
	endfunction : cmd

	function automatic logic [4:0] flg(input logic sb, input logic [31:0] x, y);
		logic [32:0] t;
		t = sb ? {1'b0, x} - {1'b0, y} : {1'b0, x} + {1'b0, y};
		return {t[32], t[31], t[31:0] == 32'h0,
			(x[31] ^ y[31] ^ !sb) & (t[31] ^ x[31]), t[32]};
	endfunction : flg

	// Word divide whose quotient overflows 16 bits leaves dst alone
	function automatic logic [31:0] dv(input int k, input logic [31:0] x, y);
		if (k == 0)
			return (x / y > 32'hffff) ? x : {16'(x % y), 16'(x / y)};
		return (k == 1) ? x / y : x % y;
	endfunction : dv

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fails++;
			final_report;
		end
	end

	initial begin
		bsp = $random(seed);
		bpc = $random(seed);
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		rc(8'h3c, bsp, "sp");
		rc(OFS_PC, bpc, "pc");
		rc(OFS_STATUS, {16'h0, SR_RESET}, "sr");
		rc(OFS_MASK, 32'hffff, "mask");
		$display("reset test done");
		for (i = 0; i < 15; i++) begin
			regs[i] = $random(seed);
			bus(1'b1, 8'(i * 4), regs[i]);
		end
		for (i = 0; i < 15; i++)
			rc(8'(i * 4), regs[i], "reg");
		for (i = 0; i < 3; i++)
			bus(1'b1, 8'(OFS_ACC + i * 4), 32'hffffffff);
		rc(OFS_ACC, 32'hffffffff, "acc");
		rc(OFS_MASK, 32'hffff, "mask");
		rc(OFS_MAC_STATUS, 32'hff, "mac_status");
		bus(1'b1, 8'h60, 32'hffffffff);
		rc(8'h60, 32'h0, "unmapped");
		vb = $random(seed);
		bus(1'b1, OFS_VBR, vb);
		vb = vb & VBR_MASK;
		rc(OFS_VBR, vb, "vbr");
		bus(1'b1, OFS_STATUS, 32'hffffffff);
		rc(OFS_STATUS, {16'h0, SR_IMPL_MASK}, "sr all");
		bus(1'b1, OFS_STATUS, {16'h0, SR_RESET});
		$display("register test done");
		for (i = 0; i < 12; i++) begin
			a = $random(seed);
			b = $random(seed);
			if (i == 0) begin
				a = 32'h7fffffff;
				b = 32'h1;
			end
			if (i == 1)
				b = a;
			if (i == 2) begin
				a = 32'hffffffff;
				b = 32'h1;
			end
			s = i[0];
			bus(1'b1, 8'h00, a);
			bus(1'b1, 8'h04, b);
			ex(cmd(s ? OP_SUB : OP_ADD, 3'h0, 3'h1, 16'h0));
			f = flg(s, a, b);
			r = s ? a - b : a + b;
			rc(8'h00, r, "result");
			rc(OFS_STATUS, {16'h0, SR_RESET | f}, "flags");
			ex(cmd(OP_MOVE, 3'h2, 3'h0, 16'h0));
			rc(OFS_STATUS, {16'h0, 8'h27, 3'h0, f[4], r[31], r == 32'h0,
				2'h0}, "move");
		end
		for (i = 0; i < 6; i++) begin
			a = $random(seed);
			b = {16'h0, 16'($random(seed))} | 32'h1;
			if (i == 3)
				a = a >> 16;
			bus(1'b1, 8'h00, a);
			bus(1'b1, 8'h04, b);
			ex(cmd(op_t'(OP_DIVW + i % 3), 3'h0, 3'h1, 16'h0));
			rc(8'h00, dv(i % 3, a, b), "divide");
		end
		bus(1'b1, OFS_STATUS, 32'h2710);
		bus(1'b1, 8'h00, a);
		ex(cmd(OP_ADDX, 3'h0, 3'h1, 16'h0));
		r = a + b + 32'h1;
		rc(8'h00, r, "addx");
		ex(cmd(OP_MOVE, 3'h0, 3'h1, 16'h0) ^ 32'h00080000);
		rc(8'h00, {r[31:8], b[7:0]}, "byte");
		$display("flag test done");
		bus(1'b1, OFS_STATUS, 32'h3300);
		irq_level <= 3'h2;
		e = 1'b0;
		repeat (10) begin
			@(posedge clk_sys);
			e = e | exception_taken;
		end
		chk("masked", {31'h0, e}, 32'h0);
		irq_level <= 3'h5;
		wex(vb + 32'h74);
		irq_level <= 3'h0;
		rc(OFS_STATUS, 32'h2500, "irq sr");
		bus(1'b1, OFS_STATUS, 32'h2700);
		irq_level <= 3'h7;
		wex(vb + 32'h7c);
		irq_level <= 3'h0;
		bus(1'b1, OFS_STATUS, 32'ha700);
		bus(1'b1, OFS_CMD, cmd(OP_NOP, 3'h0, 3'h0, 16'h0));
		wex(vb + 32'h24);
		rc(OFS_STATUS, 32'h2700, "trace sr");
		$display("interrupt test done");
		bus(1'b1, OFS_STATUS, 32'h0);
		repeat (2) @(posedge clk_sys);
		chk("user", {31'h0, supervisor_mode}, 32'h0);
		bus(1'b1, OFS_STATUS, 32'hffff);
		rc(OFS_STATUS, 32'h1f, "user sr");
		bus(1'b1, OFS_VBR, 32'hfff00000);
		rc(OFS_VBR, 32'h0, "user vbr");
		bus(1'b0, 8'h3c, 32'h0);
		sp = q;
		bus(1'b1, OFS_CMD, cmd(OP_TRAP, 3'h0, 3'h0, 16'h3));
		wex(vb + 32'h8c);
		rc(OFS_STATUS, 32'h201f, "trap sr");
		rc(8'h3c, {sp[31:2], 2'h0} - 32'h8, "frame");
		ex(cmd(OP_RTE, 3'h0, 3'h0, 16'h0));
		rc(OFS_STATUS, 32'h1f, "rte sr");
		$display("exception test done");
		final_report;
	end
endmodule : core_state_tb_top

bind core_state core_state_sva i_core_state_sva (
	.clk_sys(clk_sys), .reset(reset), .address(address), .read(read),
	.write(write), .readdata(readdata), .waitrequest(waitrequest),
	.irq_level(irq_level), .supervisor_mode(supervisor_mode),
	.vector_address(vector_address), .exception_taken(exception_taken)
);
